/* File: idp_pkg.sv */
/*
  Package for the indirect data pointer unit: widths, register slot codes,
  and reset values.
  Assumes the core presents special function register slot codes as
  defined here, one access per clock.
*/
package idp_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned HIGH_USED_W = 4;
  localparam int unsigned NUM_PAIRS = 3;

  // Slot codes the core uses to name this unit's registers and operands.
  typedef enum logic [3:0] {
    IDP_SLOT_NONE,
    IDP_SLOT_LOW_0,
    IDP_SLOT_HIGH_0,
    IDP_SLOT_LOW_1,
    IDP_SLOT_HIGH_1,
    IDP_SLOT_LOW_2,
    IDP_SLOT_HIGH_2,
    IDP_SLOT_OPERAND_0,
    IDP_SLOT_OPERAND_1,
    IDP_SLOT_OPERAND_2
  } idp_slot_t;

  localparam logic [7:0] LOW_RESET  = 8'h00;
  localparam logic [3:0] HIGH_RESET = 4'h0;
  localparam logic [3:0] HIGH_PAD   = 4'h0;
  localparam logic [7:0]  DATA_RESET = 8'h00;
  localparam logic [11:0] ADDR_RESET = 12'h000;

endpackage : idp_pkg

/* File: idp_pointer_unit.sv */
/*
  Indirect data pointer unit: three 12-bit pointer pairs and three virtual
  operands that redirect a core access to the data memory address held in
  the matching pair.
  Assumes the core issues at most one slot access per clock and that the
  data memory answers combinationally to mem_addr_out, so the byte on
  mem_rdata_in belongs to the address registered at the previous edge.
  Every read, of a pointer half or of an operand, is answered two edges
  after it is taken: the first edge presents an operand's pointer to the
  data memory, the second captures the byte that comes back. Pointer-half
  reads take the same path, so back-to-back reads of different kinds
  never collide on the result register. A pointer write is seen by an
  operand access in the very next cycle.
  Direct accesses keep the bank select register and the access-bank bit;
  only the operand path drops them.
*/
`timescale 1ns/1ps

module idp_pointer_unit
(
  input  wire logic                 clk_in,
  input  wire logic                 reset_in,
  input  wire idp_pkg::idp_slot_t   slot_in,
  input  wire logic                 read_in,
  input  wire logic                 write_in,
  input  wire logic [7:0]           wdata_in,
  input  wire logic [3:0]           bank_select_register_in,
  input  wire logic                 access_bank_in,
  input  wire logic [7:0]           direct_offset_in,
  input  wire logic [7:0]           mem_rdata_in,
  output logic      [7:0]           rdata_out,
  output logic                      rvalid_out,
  output logic      [11:0]          mem_addr_out,
  output logic      [7:0]           mem_wdata_out,
  output logic                      mem_we_out,
  output logic      [11:0]          pointer_pair_0_out,
  output logic      [11:0]          pointer_pair_1_out,
  output logic      [11:0]          pointer_pair_2_out
);

  logic [7:0]  pointer_low_half  [3];
  logic [3:0]  pointer_high_half [3];
  logic [11:0] next_addr;
  logic [7:0]  next_rdata;
  logic        is_operand;
  logic [1:0]  sel;

  // Read pipeline: what the first stage saw, waiting for the second stage
  // to pick either the held pointer half or the data memory byte.
  logic        read_pend;
  logic        pend_operand;
  logic [7:0]  pend_data;

  // Builds a full 12-bit pointer from one pair. Used for the operand
  // address and for the mirrors, so both always agree on the layout.
  function automatic logic [11:0] pair_addr(input logic [3:0] hi, input logic [7:0] lo);
    pair_addr = {hi, lo};
  endfunction : pair_addr

  // Decodes the slot into an operand flag and a pair index. Any other
  // slot leaves the flag low, so the direct address path applies.
  always_comb
  begin
    is_operand = 1'b0;
    sel        = 2'd0;
    if (slot_in == idp_pkg::IDP_SLOT_OPERAND_0)
    begin
      is_operand = 1'b1;
      sel        = 2'd0;
    end
    else if (slot_in == idp_pkg::IDP_SLOT_OPERAND_1)
    begin
      is_operand = 1'b1;
      sel        = 2'd1;
    end
    else if (slot_in == idp_pkg::IDP_SLOT_OPERAND_2)
    begin
      is_operand = 1'b1;
      sel        = 2'd2;
    end
  end

  // Picks the data memory address. The operand path uses only the pointer,
  // so bank and access-bank bit cannot leak into an indirect target; the
  // direct path keeps them for ordinary accesses.
  always_comb
  begin
    if (is_operand)
      next_addr = pair_addr(pointer_high_half[sel], pointer_low_half[sel]);
    else if (access_bank_in)
      next_addr = {bank_select_register_in, direct_offset_in};
    else
      next_addr = {4'h0, direct_offset_in};
  end

  // Selects the read value for a slot access. Operands have nothing of
  // their own to return here; their byte is taken from the data memory
  // in the second read stage.
  always_comb
  begin
    case (slot_in)
      idp_pkg::IDP_SLOT_LOW_0:  next_rdata = pointer_low_half[0];
      idp_pkg::IDP_SLOT_HIGH_0: next_rdata = {idp_pkg::HIGH_PAD, pointer_high_half[0]};
      idp_pkg::IDP_SLOT_LOW_1:  next_rdata = pointer_low_half[1];
      idp_pkg::IDP_SLOT_HIGH_1: next_rdata = {idp_pkg::HIGH_PAD, pointer_high_half[1]};
      idp_pkg::IDP_SLOT_LOW_2:  next_rdata = pointer_low_half[2];
      idp_pkg::IDP_SLOT_HIGH_2: next_rdata = {idp_pkg::HIGH_PAD, pointer_high_half[2]};
      idp_pkg::IDP_SLOT_OPERAND_0,
      idp_pkg::IDP_SLOT_OPERAND_1,
      idp_pkg::IDP_SLOT_OPERAND_2: next_rdata = idp_pkg::DATA_RESET;
      default:                  next_rdata = 8'h00;
    endcase
  end

  // Holds the pointer halves; high halves keep only four bits, so the
  // spare bits can never reach an address. Writes to operand and empty
  // slots leave the pointers alone.
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < 3; i++)
      begin
        pointer_low_half[i]  <= idp_pkg::LOW_RESET;
        pointer_high_half[i] <= idp_pkg::HIGH_RESET;
      end
    end
    else if (write_in)
    begin
      case (slot_in)
        idp_pkg::IDP_SLOT_LOW_0:  pointer_low_half[0]  <= wdata_in;
        idp_pkg::IDP_SLOT_HIGH_0: pointer_high_half[0] <= wdata_in[3:0];
        idp_pkg::IDP_SLOT_LOW_1:  pointer_low_half[1]  <= wdata_in;
        idp_pkg::IDP_SLOT_HIGH_1: pointer_high_half[1] <= wdata_in[3:0];
        idp_pkg::IDP_SLOT_LOW_2:  pointer_low_half[2]  <= wdata_in;
        idp_pkg::IDP_SLOT_HIGH_2: pointer_high_half[2] <= wdata_in[3:0];
        default: ;
      endcase
    end
  end

  // First read stage: notes a read of a real slot and holds a pointer
  // half's value while the data memory looks up an operand's byte.
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      read_pend    <= 1'b0;
      pend_operand <= 1'b0;
      pend_data    <= idp_pkg::DATA_RESET;
    end
    else
    begin
      read_pend    <= read_in && (slot_in != idp_pkg::IDP_SLOT_NONE);
      pend_operand <= read_in && is_operand;
      pend_data    <= next_rdata;
    end
  end

  // Second read stage: registers the answer two edges after the request.
  // It is zero when nothing was read, so stale data never lingers on the
  // result port between reads.
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rdata_out  <= idp_pkg::DATA_RESET;
      rvalid_out <= 1'b0;
    end
    else
    begin
      if (read_pend)
        rdata_out <= pend_operand ? mem_rdata_in : pend_data;
      else
        rdata_out <= idp_pkg::DATA_RESET;
      rvalid_out <= read_pend;
    end
  end

  // Registers the data memory request. The address also serves the first
  // read stage, so an operand read finds its byte here one edge later;
  // operand writes go to the pointed byte.
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      mem_addr_out  <= idp_pkg::ADDR_RESET;
      mem_wdata_out <= idp_pkg::DATA_RESET;
      mem_we_out    <= 1'b0;
    end
    else
    begin
      mem_addr_out  <= next_addr;
      mem_wdata_out <= wdata_in;
      mem_we_out    <= write_in && is_operand;
    end
  end

  // Mirrors the pointer pairs for the core's observation; each mirror
  // trails its registers by one edge, so a write shows here two edges
  // after it is taken.
  always_ff @(posedge clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pointer_pair_0_out <= idp_pkg::ADDR_RESET;
      pointer_pair_1_out <= idp_pkg::ADDR_RESET;
      pointer_pair_2_out <= idp_pkg::ADDR_RESET;
    end
    else
    begin
      pointer_pair_0_out <= pair_addr(pointer_high_half[0], pointer_low_half[0]);
      pointer_pair_1_out <= pair_addr(pointer_high_half[1], pointer_low_half[1]);
      pointer_pair_2_out <= pair_addr(pointer_high_half[2], pointer_low_half[2]);
    end
  end

endmodule : idp_pointer_unit

/* File: idp_mem_model.sv */
/* Data memory that stands behind the pointer unit.
   Assumes the unit holds its registered address for a whole cycle. */
`timescale 1ns/1ps
module idp_mem_model (
  input  wire logic        clk_in,
  input  wire logic        we_in,
  input  wire logic [11:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  output logic      [7:0]  rdata_out
);
  logic [7:0] mem [4096];
  // Reads answer at once, and an unwritten byte reads unknown; writes land on the edge.
  assign rdata_out = mem[addr_in];
  always @(posedge clk_in)
    if (we_in)
      mem[addr_in] <= wdata_in;
endmodule : idp_mem_model

/* File: idp_pointer_unit_asserts.sv */
/* Checker on the pointer unit ports.
   Assumes one clock and an active-high reset. */
`timescale 1ns/1ps
module idp_asserts (
  input wire logic               clk_in,
  input wire logic               reset_in,
  input wire idp_pkg::idp_slot_t slot_in,
  input wire logic               write_in,
  input wire logic [7:0]         wdata_in,
  input wire logic               read_in,
  input wire logic [7:0]         mem_rdata_in,
  input wire logic [7:0]         rdata_out,
  input wire logic               rvalid_out,
  input wire logic [11:0]        mem_addr_out,
  input wire logic [7:0]         mem_wdata_out,
  input wire logic               mem_we_out,
  input wire logic [11:0]        pointer_pair_0_out,
  input wire logic [11:0]        pointer_pair_2_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // Writes to the high half of pair 2 and to operand 2.
  wire hi = write_in && slot_in == idp_pkg::IDP_SLOT_HIGH_2;
  wire op = write_in && slot_in == idp_pkg::IDP_SLOT_OPERAND_2;
  // Writes to pair 0's low half, reads of the empty slot, of pair 0's high half and of operand 0.
  wire lo = write_in && slot_in == idp_pkg::IDP_SLOT_LOW_0;
  wire rn = read_in && slot_in == idp_pkg::IDP_SLOT_NONE;
  wire rh = read_in && slot_in == idp_pkg::IDP_SLOT_HIGH_0;
  wire ro = read_in && slot_in == idp_pkg::IDP_SLOT_OPERAND_0;
  // Any operand write.
  wire ow = write_in && (slot_in == idp_pkg::IDP_SLOT_OPERAND_0 ||
                         slot_in == idp_pkg::IDP_SLOT_OPERAND_1 ||
                         slot_in == idp_pkg::IDP_SLOT_OPERAND_2);
  property p_hi; hi |-> ##2 pointer_pair_2_out[11:8] == $past(wdata_in[3:0], 2); endproperty
  a_hi: assert property (p_hi) else $error("high half lost");
  property p_op;
    op |=> mem_we_out && mem_addr_out == pointer_pair_2_out && mem_wdata_out == $past(wdata_in);
  endproperty
  a_op: assert property (p_op) else $error("operand write misrouted");
  property p_kp; op |-> ##2 $stable(pointer_pair_2_out); endproperty
  a_kp: assert property (p_kp) else $error("pointer moved");
  c_hi: cover property (hi);
  c_op: cover property (op);
  property p_lo; lo |-> ##2 pointer_pair_0_out[7:0] == $past(wdata_in, 2); endproperty
  a_lo: assert property (p_lo) else $error("low half lost");
  property p_rn; rn |-> ##2 !rvalid_out; endproperty
  a_rn: assert property (p_rn) else $error("empty slot answered");
  property p_rh; rh |-> ##2 rvalid_out && rdata_out[7:4] == 4'h0; endproperty
  a_rh: assert property (p_rh) else $error("high half spare bits set");
  property p_ro;
    ro |=> !mem_we_out && mem_addr_out == pointer_pair_0_out
      ##1 rvalid_out && rdata_out == $past(mem_rdata_in);
  endproperty
  a_ro: assert property (p_ro) else $error("operand read misrouted");
  property p_nw; !ow |=> !mem_we_out; endproperty
  a_nw: assert property (p_nw) else $error("stray memory write");
  c_we: cover property (mem_we_out);
  c_rd: cover property (rvalid_out);
endmodule : idp_asserts
bind idp_pointer_unit idp_asserts u_chk (
  .clk_in             (clk_in),
  .reset_in           (reset_in),
  .slot_in            (slot_in),
  .write_in           (write_in),
  .wdata_in           (wdata_in),
  .read_in            (read_in),
  .mem_rdata_in       (mem_rdata_in),
  .rdata_out          (rdata_out),
  .rvalid_out         (rvalid_out),
  .mem_addr_out       (mem_addr_out),
  .mem_wdata_out      (mem_wdata_out),
  .mem_we_out         (mem_we_out),
  .pointer_pair_0_out (pointer_pair_0_out),
  .pointer_pair_2_out (pointer_pair_2_out)
);

/* File: tb_indirect_data_pointer_unit.sv */
/* Bench for the pointer unit.
   Assumes the memory model answers reads at once. */
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin error_cnt++; $display("ERROR %0t mismatch", $time); end end
module tb_indirect_data_pointer_unit;
  logic               clk_in = 0;
  logic               reset_in, read_in, write_in, rvalid_out, mem_we_out, bank_bit;
  logic [3:0]         bank;
  logic [7:0]         wdata_in, mem_rdata_in, rdata_out, mem_wdata_out, offset;
  logic [11:0]        mem_addr_out, p [3];
  idp_pkg::idp_slot_t slot_in;
  int                 error_cnt, checked;
  // Bank and offset hold a direct address that operands must ignore.
  idp_pointer_unit DUT (.clk_in(clk_in), .reset_in(reset_in), .slot_in(slot_in),
    .read_in(read_in), .write_in(write_in), .wdata_in(wdata_in),
    .bank_select_register_in(bank), .access_bank_in(bank_bit),
    .direct_offset_in(offset), .mem_rdata_in(mem_rdata_in), .rdata_out(rdata_out),
    .rvalid_out(rvalid_out), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out),
    .mem_we_out(mem_we_out), .pointer_pair_0_out(p[0]), .pointer_pair_1_out(p[1]),
    .pointer_pair_2_out(p[2]));
  idp_mem_model MEM (.clk_in(clk_in), .we_in(mem_we_out), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));
  // Clock with a 4 ns period.
  initial forever #2 clk_in = ~clk_in;
  // One read or write, taken at the next edge.
  task automatic go(input int t, input logic r, input logic [7:0] v);
    @(posedge clk_in) #1 slot_in = idp_pkg::idp_slot_t'(t);
    {read_in, write_in, wdata_in} = {r, !r, v};
    @(posedge clk_in) #1 {read_in, write_in} = 2'b00;
  endtask : go
  // Loads each pair with the spare high bits set, then reads the high half back.
  task automatic t_ptr;
    for (int n = 0; n < 3; n++)
    begin
      go(2 * n + 1, 0, 8'(n + 'h3c));
      go(2 * n + 2, 0, 8'(n + 'hf1));
      go(2 * n + 2, 1, 8'h00);
      @(posedge clk_in) #1;
      `CHK({rvalid_out, rdata_out}, {1'b1, 8'(n + 1)})
      `CHK(p[n], {4'(n + 1), 8'(n + 'h3c)})
    end
  endtask : t_ptr
  // Direct accesses follow bank and offset; empty slots neither answer nor store.
  task automatic t_direct;
    bank_bit = 1'b0;
    go(0, 1, 8'h00);
    `CHK(mem_addr_out, {4'h0, offset})
    @(posedge clk_in) #1;
    `CHK({rvalid_out, rdata_out, mem_we_out}, 10'h000)
    bank_bit = 1'b1;
    go(0, 0, 8'h5a);
    `CHK({mem_we_out, mem_addr_out}, {1'b0, bank, offset})
    @(posedge clk_in) #1;
    `CHK(p[0], 12'h13c)
  endtask : t_direct
  // Writes each operand under a new bank, then reads it back through the same pointer.
  task automatic t_op;
    for (int n = 0; n < 3; n++)
    begin
      bank = 4'(n + 9);
      go(n + 7, 0, 8'(n ^ 'ha5));
      `CHK({mem_we_out, mem_wdata_out}, {1'b1, 8'(n ^ 'ha5)})
      `CHK(mem_addr_out, {4'(n + 1), 8'(n + 'h3c)})
      go(n + 7, 1, 8'h00);
      `CHK({mem_we_out, mem_addr_out}, {1'b0, 4'(n + 1), 8'(n + 'h3c)})
      @(posedge clk_in) #1;
      `CHK({rvalid_out, rdata_out}, {1'b1, 8'(n ^ 'ha5)})
      `CHK(p[n], {4'(n + 1), 8'(n + 'h3c)})
    end
  endtask : t_op
  // A reset in mid-run clears every pointer and silences the outputs.
  task automatic t_reset;
    @(posedge clk_in) #1 reset_in = 1;
    @(posedge clk_in) #1;
    `CHK({p[0], p[1], p[2], rvalid_out, mem_we_out}, 38'h0)
    reset_in = 0;
    go(2, 1, 8'h00);
    @(posedge clk_in) #1;
    `CHK({rvalid_out, rdata_out, p[0]}, {1'b1, 8'h00, 12'h000})
  endtask : t_reset
  task automatic final_report;
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Reset for 16 cycles, then all four scenarios.
  initial
  begin
    {read_in, write_in, wdata_in, error_cnt, checked} = 0;
    {bank, bank_bit, offset} = {4'h5, 1'b1, 8'h77};
    slot_in = idp_pkg::IDP_SLOT_NONE;
    reset_in = 1;
    repeat (16) @(posedge clk_in);
    #1 reset_in = 0;
    t_ptr();
    t_direct();
    t_op();
    t_reset();
    final_report();
  end
  // Watchdog well past the roughly 63 cycles the tests need.
  initial
  begin
    #5000 error_cnt++;
    final_report();
  end
endmodule : tb_indirect_data_pointer_unit
